/* hw/iak_handler.sv */
// Interrupt acknowledge handler: drives one acknowledge cycle on the bus.
// How it works
// - Acknowledge low, level coded on address lines
// - Strobes and long-word select byte width
// - Every valid handler line driven valid
// - Required-low lines actively driven low
// - Required-high lines actively driven high
// - Optional-high lines driven high, never low
// - Don't-care lines left undriven
// - Level and long-word stable until response
`timescale 1ns/1ps
module iak_handler
    import iak_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    input wire logic [IAK_LEVEL_W-1:0] level,
    input wire iak_width_type width,
    output logic busy,
    output logic done,
    output iak_result_type result,
    input wire logic bus_granted,
    input wire logic as_in_b,
    input wire logic dtack_in_b,
    input wire logic berr_in_b,
    input wire logic [IAK_DATA_W-1:0] data_in,
    output iak_bus_out_type bus_out,
    output logic bus_oe
);
    typedef enum logic [2:0] {
        IAK_IDLE, IAK_WAIT_BUS, IAK_SETUP, IAK_ADDR, IAK_STROBE, IAK_HOLD, IAK_RELEASE
    } iak_state_type;

    iak_state_type state_reg;
    logic [IAK_LEVEL_W-1:0] level_reg;
    iak_width_type width_reg;
    iak_bus_out_type bus_reg;
    iak_result_type result_reg;
    logic berr_seen_reg;
    logic oe_reg;
    logic done_reg;
    logic dly_load;
    logic [IAK_CNT_W-1:0] dly_count;
    logic dly_done;
    logic responded;
    logic setup_met_reg;
    logic addr_go;

    // Mask of lanes the acknowledged width makes valid
    function automatic logic [IAK_DATA_W-1:0] iak_lane_mask(input iak_width_type w);
        unique case (w)
            IAK_SINGLE_BYTE_ACK: iak_lane_mask = 32'h000000FF;
            IAK_DOUBLE_BYTE_ACK: iak_lane_mask = 32'h0000FFFF;
            IAK_QUAD_BYTE_ACK: iak_lane_mask = 32'hFFFFFFFF;
            default: iak_lane_mask = 32'h000000FF;
        endcase
    endfunction : iak_lane_mask

    assign responded = !dtack_in_b || !berr_in_b;
    // Setup met; a stale response from the last cycle may still hold the strobe off
    assign addr_go = (dly_done || setup_met_reg) && dtack_in_b && berr_in_b;
    assign dly_load = (state_reg == IAK_WAIT_BUS && bus_granted && as_in_b)
        || (state_reg == IAK_SETUP && dly_done)
        || (state_reg == IAK_STROBE && responded);
    assign dly_count = (state_reg == IAK_WAIT_BUS) ? 4'(IAK_DS_HIGH_CYC)
        : (state_reg == IAK_SETUP) ? 4'(IAK_ADDR_SETUP_CYC) : 4'(IAK_DATA_HOLD_CYC);

    iak_delay u_delay (
        .clk(clk),
        .rst_b(rst_b),
        .load(dly_load),
        .count(dly_count),
        .done(dly_done)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= IAK_IDLE;
        end else begin
            unique case (state_reg)
                IAK_IDLE: if (start) state_reg <= IAK_WAIT_BUS;
                IAK_WAIT_BUS: if (bus_granted && as_in_b) state_reg <= IAK_SETUP;
                IAK_SETUP: if (dly_done) state_reg <= IAK_ADDR;
                IAK_ADDR: if (addr_go) state_reg <= IAK_STROBE;
                IAK_STROBE: if (responded) state_reg <= IAK_HOLD;
                IAK_HOLD: if (dly_done) state_reg <= IAK_RELEASE;
                IAK_RELEASE: if (dtack_in_b && berr_in_b) state_reg <= IAK_IDLE;
            endcase
        end
    end

    // Done pulse is one cycle; remember it so the strobe waits without hanging
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            setup_met_reg <= 1'b0;
        end else begin
            setup_met_reg <= (state_reg == IAK_ADDR) && (dly_done || setup_met_reg) && !addr_go;
        end
    end

    // Request latched so level and width stay put for the whole cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            level_reg <= 3'h1;
            width_reg <= IAK_SINGLE_BYTE_ACK;
        end else if (state_reg == IAK_IDLE && start) begin
            level_reg <= level;
            width_reg <= width;
        end
    end

    // Bus line levels; every driven line is at a defined level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_reg <= '{iack_b: 1'b1, addr: 3'h0, lword_b: 1'b1, write_b: 1'b1,
                         as_b: 1'b1, ds0_b: 1'b1, ds1_b: 1'b1};
            oe_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                IAK_WAIT_BUS: if (bus_granted && as_in_b) begin
                    oe_reg <= 1'b1;
                    bus_reg.iack_b <= 1'b0;
                    bus_reg.addr <= level_reg;
                    bus_reg.lword_b <= (width_reg != IAK_QUAD_BYTE_ACK);
                    bus_reg.write_b <= 1'b1;
                end
                IAK_SETUP: if (dly_done) bus_reg.as_b <= 1'b0;
                IAK_ADDR: if (addr_go) begin
                    bus_reg.ds0_b <= 1'b0;
                    bus_reg.ds1_b <= (width_reg == IAK_SINGLE_BYTE_ACK);
                end
                IAK_HOLD: if (dly_done) begin
                    bus_reg.as_b <= 1'b1;
                    bus_reg.ds0_b <= 1'b1;
                    bus_reg.ds1_b <= 1'b1;
                end
                IAK_RELEASE: if (dtack_in_b && berr_in_b) begin
                    oe_reg <= 1'b0;
                    bus_reg.iack_b <= 1'b1;
                    bus_reg.lword_b <= 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    // Status/identity captured after settle time; error returns nothing
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            result_reg <= '0;
            berr_seen_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (state_reg == IAK_STROBE && responded) begin
                berr_seen_reg <= !berr_in_b;
            end
            if (state_reg == IAK_HOLD && dly_done) begin
                result_reg.ok <= !berr_seen_reg;
                result_reg.bus_error <= berr_seen_reg;
                result_reg.status_id <= berr_seen_reg ? 32'h0
                    : (data_in & iak_lane_mask(width_reg));
            end
            if (state_reg == IAK_RELEASE && dtack_in_b && berr_in_b) begin
                done_reg <= 1'b1;
            end
        end
    end

    assign bus_out = bus_reg;
    assign bus_oe = oe_reg;
    assign busy = (state_reg != IAK_IDLE);
    assign done = done_reg;
    assign result = result_reg;

    property p_iack_level_stable;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == IAK_STROBE) |-> bus_oe && !bus_out.iack_b && $stable(bus_out.addr)
            && $stable(bus_out.lword_b);
    endproperty
    a_iack_level_stable: assert property (p_iack_level_stable)
        else $error("level code or long-word moved before response");

    property p_level_code;
        @(posedge clk) disable iff (!rst_b)
        (bus_oe && !bus_out.iack_b) |-> (bus_out.addr == level_reg);
    endproperty
    a_level_code: assert property (p_level_code)
        else $error("address lines do not carry acknowledged level");

    property p_lword_width;
        @(posedge clk) disable iff (!rst_b)
        (bus_oe && !bus_out.iack_b) |-> (bus_out.lword_b == (width_reg != IAK_QUAD_BYTE_ACK));
    endproperty
    a_lword_width: assert property (p_lword_width)
        else $error("long-word line wrong for width");

    property p_ds1_single_high;
        @(posedge clk) disable iff (!rst_b)
        (width_reg == IAK_SINGLE_BYTE_ACK && state_reg != IAK_IDLE) |-> bus_out.ds1_b;
    endproperty
    a_ds1_single_high: assert property (p_ds1_single_high)
        else $error("upper strobe driven low in single byte cycle");

    property p_write_high;
        @(posedge clk) disable iff (!rst_b)
        bus_oe |-> bus_out.write_b;
    endproperty
    a_write_high: assert property (p_write_high)
        else $error("read/write line driven low");

    sequence s_strobe_resp;
        (state_reg == IAK_STROBE) && responded;
    endsequence
    sequence s_released_consistent;
        (state_reg == IAK_RELEASE) && (result.bus_error == !result.ok);
    endsequence
    property p_capture;
        @(posedge clk) disable iff (!rst_b)
        s_strobe_resp |-> ##[2:8] s_released_consistent;
    endproperty
    a_capture: assert property (p_capture)
        else $error("result flags inconsistent after capture");

    property p_berr_no_id;
        @(posedge clk) disable iff (!rst_b)
        (state_reg == IAK_STROBE && !berr_in_b) |-> ##[1:8] (result.bus_error
            && result.status_id == 32'h0);
    endproperty
    a_berr_no_id: assert property (p_berr_no_id)
        else $error("bus error did not yield empty result");

    property p_lane_mask;
        @(posedge clk) disable iff (!rst_b)
        (width_reg != IAK_QUAD_BYTE_ACK && state_reg == IAK_RELEASE)
            |-> (result.status_id[31:16] == 16'h0);
    endproperty
    a_lane_mask: assert property (p_lane_mask)
        else $error("lanes above width captured");

    property p_drive_only_when_granted;
        @(posedge clk) disable iff (!rst_b)
        $rose(bus_oe) |-> $past(bus_granted) && $past(as_in_b);
    endproperty
    a_drive_only_when_granted: assert property (p_drive_only_when_granted)
        else $error("bus driven without grant");
endmodule : iak_handler

/* hw/iak_pkg.sv */
// Package for the interrupt acknowledge handler: widths, codes, timing counts.
package iak_pkg;
    localparam int IAK_LEVEL_W = 3;
    localparam int IAK_DATA_W = 32;
    localparam int IAK_CLK_PERIOD_NS = 10;
    // Address strobe low before data strobes fall, least time
    localparam int IAK_ADDR_SETUP_NS = 35;
    localparam int IAK_ADDR_SETUP_CYC = (IAK_ADDR_SETUP_NS + IAK_CLK_PERIOD_NS - 1)
        / IAK_CLK_PERIOD_NS;
    // Data strobes high before a strobe falls, least time
    localparam int IAK_DS_HIGH_NS = 40;
    localparam int IAK_DS_HIGH_CYC = (IAK_DS_HIGH_NS + IAK_CLK_PERIOD_NS - 1)
        / IAK_CLK_PERIOD_NS;
    // Strobes held after acknowledge seen low so data settles
    localparam int IAK_DATA_HOLD_NS = 25;
    localparam int IAK_DATA_HOLD_CYC = (IAK_DATA_HOLD_NS + IAK_CLK_PERIOD_NS - 1)
        / IAK_CLK_PERIOD_NS;
    localparam int IAK_CNT_W = 4;

    typedef enum logic [1:0] {
        IAK_SINGLE_BYTE_ACK,
        IAK_DOUBLE_BYTE_ACK,
        IAK_QUAD_BYTE_ACK
    } iak_width_type;

    // Handler-driven bus lines; all active-low lines carry _b
    typedef struct packed {
        logic iack_b;
        logic [IAK_LEVEL_W-1:0] addr;
        logic lword_b;
        logic write_b;
        logic as_b;
        logic ds0_b;
        logic ds1_b;
    } iak_bus_out_type;

    typedef struct packed {
        logic ok;
        logic bus_error;
        logic [IAK_DATA_W-1:0] status_id;
    } iak_result_type;
endpackage : iak_pkg

/* hw/iak_delay.sv */
// Down-counter giving a one-cycle done pulse after a loaded count.
`timescale 1ns/1ps
module iak_delay
    import iak_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [IAK_CNT_W-1:0] count,
    output logic done
);
    logic [IAK_CNT_W-1:0] cnt_reg;
    logic run_reg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
            run_reg <= 1'b0;
        end else if (load) begin
            cnt_reg <= count;
            run_reg <= 1'b1;
        end else if (run_reg) begin
            if (cnt_reg <= 4'h1) begin
                run_reg <= 1'b0;
            end
            cnt_reg <= cnt_reg - 4'h1;
        end
    end

    assign done = run_reg && (cnt_reg <= 4'h1);
endmodule : iak_delay

/* test/iak_irq_model.sv */
// Behavioural interrupter answering one acknowledge level.
`timescale 1ns/1ps
module iak_irq_model
    import iak_pkg::*;
#(
    parameter logic [31:0] STATUS_ID = 32'h5AC3_96E1
)(
    input wire logic clk,
    input wire logic rst_b,
    input wire iak_bus_out_type bus_out,
    input wire logic bus_oe,
    input wire logic [2:0] pend_level,
    input wire logic [1:0] cap,
    input wire logic err,
    input wire logic [7:0] dly,
    output logic dtack_b,
    output logic berr_b,
    output logic [31:0] data,
    output logic ack_out_b
);
    logic [7:0] wait_reg;
    logic sel;
    logic resp;
    // Other levels are passed down the chain, never answered
    assign sel = bus_oe && !bus_out.iack_b && !bus_out.as_b && !bus_out.ds0_b
        && bus_out.addr == pend_level;
    assign resp = sel && wait_reg >= dly;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg <= 8'h00;
        end else if (!sel) begin
            wait_reg <= 8'h00;
        end else if (!resp) begin
            wait_reg <= wait_reg + 8'h01;
        end
    end
    // Pass-on decided from registered lines only, so no low-going transient
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_out_b <= 1'b1;
        end else begin
            ack_out_b <= !(bus_oe && !bus_out.iack_b && !bus_out.as_b
                && bus_out.addr != pend_level);
        end
    end
    // Freed once strobes rise so the next cycle finds idle lines
    assign dtack_b = !(resp && !err);
    assign berr_b = !(resp && err);
    // Terminators pull free lanes high; narrow lanes above width stay high
    always_comb begin
        data = 32'hFFFF_FFFF;
        if (resp && !err) begin
            case (cap)
                2'h0: data = {24'hFF_FFFF, STATUS_ID[7:0]};
                2'h1: data = {16'hFFFF, STATUS_ID[15:0]};
                default: data = STATUS_ID;
            endcase
        end
    end
endmodule : iak_irq_model

/* test/tb.sv */
// Self-checking bench for the interrupt acknowledge handler.
`timescale 1ns/1ps
module tb;
    import iak_pkg::*;
    localparam logic [31:0] ID = 32'h5AC3_96E1;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic start = 1'b0;
    logic [2:0] level = 3'h1;
    iak_width_type width = IAK_SINGLE_BYTE_ACK;
    logic busy, done, bus_oe, dtack_b, berr_b, ack_out_b;
    iak_result_type result;
    iak_bus_out_type bus_out;
    logic bus_granted = 1'b1;
    logic as_in_b = 1'b1;
    logic [31:0] data;
    logic [1:0] cap = 2'h2;
    logic err = 1'b0;
    logic [7:0] dly = 8'h00;
    logic [2:0] exp_lv = 3'h1;
    iak_width_type exp_w = IAK_SINGLE_BYTE_ACK;
    int n_errors = 0;
    int comparisons = 0;
    always #5 clk = ~clk;
    iak_handler DUT (.clk(clk), .rst_b(rst_b), .start(start), .level(level), .width(width),
        .busy(busy), .done(done), .result(result), .bus_granted(bus_granted),
        .as_in_b(as_in_b), .dtack_in_b(dtack_b), .berr_in_b(berr_b), .data_in(data),
        .bus_out(bus_out), .bus_oe(bus_oe));
    iak_irq_model #(.STATUS_ID(ID)) u_irq (.clk(clk), .rst_b(rst_b), .bus_out(bus_out),
        .bus_oe(bus_oe), .pend_level(exp_lv), .cap(cap), .err(err), .dly(dly),
        .dtack_b(dtack_b), .berr_b(berr_b), .data(data), .ack_out_b(ack_out_b));
    task automatic chk(input logic ok, input string msg);
        comparisons++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done
    function automatic logic [31:0] exp_id(input logic [1:0] c, input iak_width_type w);
        logic [31:0] v;
        v = c == 2'h0 ? {24'hFF_FFFF, ID[7:0]} : c == 2'h1 ? {16'hFFFF, ID[15:0]} : ID;
        if (w == IAK_SINGLE_BYTE_ACK) return {24'h0, v[7:0]};
        if (w == IAK_DOUBLE_BYTE_ACK) return {16'h0, v[15:0]};
        return v;
    endfunction : exp_id
    // Lines that must stand from address strobe until released
    always @(negedge clk) begin
        if (bus_oe === 1'b1 && bus_out.as_b === 1'b0) begin
            chk(bus_out.iack_b === 1'b0 && bus_out.addr === exp_lv, "level code");
            chk(bus_out.write_b === 1'b1, "write line low");
            chk(ack_out_b === 1'b1, "responder passed acknowledge on");
            chk(bus_out.lword_b === (exp_w != IAK_QUAD_BYTE_ACK), "long-word");
            if (bus_out.ds0_b === 1'b0) begin
                chk(bus_out.ds1_b === (exp_w == IAK_SINGLE_BYTE_ACK), "strobes");
            end
        end
    end
    task automatic ack(input logic [2:0] lv, input iak_width_type w, input logic [1:0] c,
        input logic e, input logic [7:0] d, input bit poke);
        int i;
        @(negedge clk);
        level = lv;
        width = w;
        exp_lv = lv;
        exp_w = w;
        cap = c;
        err = e;
        dly = d;
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        // A second request mid-cycle must be ignored
        level = poke ? 3'h7 : lv;
        for (i = 0; i < 400 && done !== 1'b1; i++) begin
            start = poke && i == 12;
            @(negedge clk);
        end
        chk(done === 1'b1, "no done");
        chk(result.ok === !e && result.bus_error === e, "response kind");
        chk(result.status_id === (e ? 32'h0 : exp_id(c, w)), "status id");
    endtask : ack
    task automatic t_grant();
        bus_granted = 1'b0;
        as_in_b = 1'b0;
        fork
            ack(3'h3, IAK_QUAD_BYTE_ACK, 2'h2, 1'b0, 8'h01, 1'b0);
            begin
                repeat (10) @(negedge clk);
                chk(bus_oe === 1'b0 && busy === 1'b1, "drove before grant");
                bus_granted = 1'b1;
                repeat (5) @(negedge clk);
                chk(bus_oe === 1'b0, "drove on busy bus");
                as_in_b = 1'b1;
            end
        join
    endtask : t_grant
    task automatic t_levels();
        for (int lv = 1; lv < 8; lv++) begin
            ack(3'(lv), iak_width_type'(lv % 3), 2'h2, 1'b0, 8'h00, 1'b0);
        end
    endtask : t_levels
    task automatic t_widths();
        for (int w = 0; w < 3; w++) begin
            for (int c = 0; c < 3; c++) begin
                ack(3'(w + c + 1), iak_width_type'(w), 2'(c), 1'b0, 8'h02, 1'b0);
            end
        end
    endtask : t_widths
    task automatic t_berr_slow();
        ack(3'h5, IAK_DOUBLE_BYTE_ACK, 2'h1, 1'b1, 8'h02, 1'b0);
        ack(3'h6, IAK_QUAD_BYTE_ACK, 2'h2, 1'b0, 8'h28, 1'b1);
    endtask : t_berr_slow
    initial begin
        repeat (8) @(negedge clk);
        chk(bus_oe === 1'b0 && busy === 1'b0 && done === 1'b0, "reset state");
        rst_b = 1'b1;
        t_grant();
        t_levels();
        t_widths();
        t_berr_slow();
        test_done();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        #200000;
        n_errors++;
        test_done();
    end
endmodule : tb
